/* core/event_routing_consts.svh */
`ifndef EVENT_ROUTING_CONSTS_SVH
`define EVENT_ROUTING_CONSTS_SVH

`define SEL_HIGH_ADDR 32'h019c0000
`define SEL_LOW_ADDR 32'h019c0004
`define FIELD_W 5
`define FIELD0_LSB 0
`define FIELD1_LSB 5
`define FIELD2_LSB 10
`define FIELD3_LSB 16
`define FIELD4_LSB 21
`define FIELD5_LSB 26
`define SEL_LOW_RESET 32'h250718a4
`define SEL_HIGH_RESET 32'h08202d43
`define SEL_WRITE_MASK 32'h7fff7fff
`define IRQ_STATUS_ADDR 32'h019c0008
`define IRQ_MASK_ADDR 32'h019c000c
`define NUM_CPU_INT 16
`define NUM_SRC 32
`define NUM_CHAN 64

`endif

/* core/event_routing_pkg.sv */
package event_routing_pkg;

  typedef logic [4:0] sel_code_t;

  typedef struct packed {
    logic [31:0] sel_high;
    logic [31:0] sel_low;
    logic [15:0] irq_status;
    logic [15:0] irq_mask;
    logic [31:0] rdata;
    logic irq;
    logic [15:0] cpu_int;
    logic [63:0] chan_event;
  } router_state_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

/* core/event_routing_selector.sv */
// What this block does
// - Sixteen prioritized core interrupt lines; line zero highest, fifteen lowest.
// - Lines zero to three fixed: reset, non-maskable, two reserved zero.
// - Lines four to fifteen each pick a source by a five-bit code.
// - High selector at 0x019c0000, low selector at 0x019c0004, read and write.
// - Low fields for lines four to nine at bits 4:0 to 30:26.
// - High fields for lines ten to fifteen in the same layout.
// - Low fields reset to codes 4,5,6,7,8,9.
// - Decode all documented source codes to their event lines.
// - Channels zero to three: host, timer zero, timer one, refresh A.
// - Channels 4-7 GPIO 4-7, 8-11 GPIO 0-3, 48-55 GPIO 8-15.
// - Serial, timer two, refresh B, coprocessor, cell channels; rest none.
// - Every channel also syncs on completion or alternate completion.
// - Channel events are presented regardless of any enable.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "event_routing_consts.svh"

module event_routing_selector (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  input wire logic nmi_i,
  input wire logic host_event_i,
  input wire logic timer_zero_event_i,
  input wire logic timer_one_event_i,
  input wire logic timer_two_event_i,
  input wire logic memif_a_refresh_event_i,
  input wire logic memif_b_refresh_event_i,
  input wire logic [15:0] gpio_event_i,
  input wire logic transfer_complete_event_i,
  input wire logic debug_dma_event_i,
  input wire logic debug_exchange_rx_event_i,
  input wire logic debug_exchange_tx_event_i,
  input wire logic [2:0] serial_tx_event_i,
  input wire logic [2:0] serial_rx_event_i,
  input wire logic [2:0] serial_tx_sync_i,
  input wire logic [2:0] serial_rx_sync_i,
  input wire logic cell_interface_event_i,
  input wire logic cell_rx_sync_i,
  input wire logic cell_tx_sync_i,
  input wire logic conv_decoder_event_i,
  input wire logic iter_decoder_event_i,
  input wire logic conv_decoder_rx_sync_i,
  input wire logic conv_decoder_tx_sync_i,
  input wire logic iter_decoder_rx_sync_i,
  input wire logic iter_decoder_tx_sync_i,
  input wire logic [63:0] chain_complete_i,
  input wire logic [63:0] alt_chain_complete_i,
  output logic [15:0] cpu_int_o,
  output logic [63:0] chan_event_o
);

  event_routing_pkg::router_state_s q, d;
  event_routing_pkg::reg_req_s req;
  logic [31:0] src;
  logic [63:0] chan;
  logic [31:0] wval;
  logic [31:0] fld_lsb [6];

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign fld_lsb = '{`FIELD0_LSB, `FIELD1_LSB, `FIELD2_LSB,
                     `FIELD3_LSB, `FIELD4_LSB, `FIELD5_LSB};

  ////////////////////////////////////////////////////////////////////////////
  // source decode; reserved codes stay low
  always_comb begin
    src = 32'h00000000;
    src[0] = host_event_i;
    src[1] = timer_zero_event_i;
    src[2] = timer_one_event_i;
    src[3] = memif_a_refresh_event_i;
    src[7:4] = gpio_event_i[7:4];
    src[8] = transfer_complete_event_i;
    src[9] = debug_dma_event_i;
    src[10] = debug_exchange_rx_event_i;
    src[11] = debug_exchange_tx_event_i;
    src[12] = serial_tx_event_i[0];
    src[13] = serial_rx_event_i[0];
    src[14] = serial_tx_event_i[1];
    src[15] = serial_rx_event_i[1];
    src[16] = gpio_event_i[0];
    src[17] = serial_tx_event_i[2];
    src[18] = serial_rx_event_i[2];
    src[19] = timer_two_event_i;
    src[20] = memif_b_refresh_event_i;
    src[23] = cell_interface_event_i;
    src[30] = conv_decoder_event_i;
    src[31] = iter_decoder_event_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // fixed channel map
  always_comb begin
    chan = 64'h0000000000000000;
    chan[0] = host_event_i;
    chan[1] = timer_zero_event_i;
    chan[2] = timer_one_event_i;
    chan[3] = memif_a_refresh_event_i;
    chan[7:4] = gpio_event_i[7:4];
    chan[11:8] = gpio_event_i[3:0];
    chan[55:48] = gpio_event_i[15:8];
    chan[12] = serial_tx_sync_i[0];
    chan[13] = serial_rx_sync_i[0];
    chan[14] = serial_tx_sync_i[1];
    chan[15] = serial_rx_sync_i[1];
    chan[17] = serial_tx_sync_i[2];
    chan[18] = serial_rx_sync_i[2];
    chan[19] = timer_two_event_i;
    chan[20] = memif_b_refresh_event_i;
    chan[28] = conv_decoder_rx_sync_i;
    chan[29] = conv_decoder_tx_sync_i;
    chan[30] = iter_decoder_rx_sync_i;
    chan[31] = iter_decoder_tx_sync_i;
    chan[32] = cell_rx_sync_i;
    chan[40] = cell_tx_sync_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    wval = req.wdata & `SEL_WRITE_MASK;
    if (req.wr && req.addr == `SEL_HIGH_ADDR) begin
      d.sel_high = wval;
    end
    if (req.wr && req.addr == `SEL_LOW_ADDR) begin
      d.sel_low = wval;
    end
    if (req.wr && req.addr == `IRQ_MASK_ADDR) begin
      d.irq_mask = req.wdata[15:0];
    end
    // Set wins over write-one-to-clear
    if (req.wr && req.addr == `IRQ_STATUS_ADDR) begin
      d.irq_status = q.irq_status & ~req.wdata[15:0];
    end
    // core lines, zero is highest priority
    d.cpu_int = 16'h0000;
    // fixed lines; two and three reserved
    d.cpu_int[0] = ~rst_b_i;
    d.cpu_int[1] = nmi_i;
    // routing uses current fields, next clock
    for (int i = 0; i < 6; i++) begin
      // low fields feed lines four to nine
      d.cpu_int[4 + i] = src[q.sel_low[fld_lsb[i] +: `FIELD_W]];
      // high fields feed lines ten to fifteen
      d.cpu_int[10 + i] = src[q.sel_high[fld_lsb[i] +: `FIELD_W]];
    end
    d.irq_status = d.irq_status | {d.cpu_int[15:4], 4'h0};
    d.irq = |(q.irq_status & q.irq_mask);
    // no enable gates the channel events
    d.chan_event = chan | chain_complete_i | alt_chain_complete_i;
    d.rdata = 32'h00000000;
    if (req.rd) begin
      case (req.addr)
        `SEL_HIGH_ADDR: d.rdata = q.sel_high;
        `SEL_LOW_ADDR: d.rdata = q.sel_low;
        `IRQ_STATUS_ADDR: d.rdata = {16'h0000, q.irq_status};
        `IRQ_MASK_ADDR: d.rdata = {16'h0000, q.irq_mask};
        default: d.rdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
      q.sel_low <= `SEL_LOW_RESET;
      q.sel_high <= `SEL_HIGH_RESET;
      q.cpu_int <= 16'h0001;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign irq_o = q.irq;
  assign cpu_int_o = q.cpu_int;
  assign chan_event_o = q.chan_event;

endmodule

/* verif/core_event_sink.sv */
`timescale 1ns/1ps
module core_event_sink (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [63:0] chan_event_i,
  output logic [63:0] captured_o
);
  // Capture ignores enable
  // Sticky, so a one-cycle event is never lost
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      captured_o <= 64'h0;
    end else begin
      captured_o <= captured_o | chan_event_i;
    end
  end
endmodule

/* verif/event_routing_selector_assertions.sv */
`timescale 1ns/1ps
module event_routing_checker (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic nmi_i,
  input wire logic host_event_i,
  input wire logic [63:0] chain_complete_i,
  input wire logic [63:0] alt_chain_complete_i,
  input wire logic [15:0] cpu_int_o,
  input wire logic [63:0] chan_event_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_top; cpu_int_o[0] == !$past(rst_b_i); endproperty
  a_top: assert property (p_top) else $error("line0");
  property p_rls; $rose(rst_b_i) |-> cpu_int_o[0] ##1 !cpu_int_o[0];
  endproperty
  a_rls: assert property (p_rls) else $error("line0 hold");
  property p_nmi; $past(rst_b_i) |-> cpu_int_o[1] == $past(nmi_i);
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi");
  property p_rsv; cpu_int_o[3:2] == 2'b00; endproperty
  a_rsv: assert property (p_rsv) else $error("lines 2 3");
  property p_ch0; $past(rst_b_i) |-> chan_event_o[0] ==
    $past(host_event_i | chain_complete_i[0] | alt_chain_complete_i[0]);
  endproperty
  a_ch0: assert property (p_ch0) else $error("chan0");
  property p_top8; $past(rst_b_i) |-> chan_event_o[63:56] ==
    $past(chain_complete_i[63:56] | alt_chain_complete_i[63:56]);
  endproperty
  a_top8: assert property (p_top8) else $error("chan 56-63");
  property p_ch21; $past(rst_b_i) |-> chan_event_o[21] ==
    $past(chain_complete_i[21] | alt_chain_complete_i[21]);
  endproperty
  a_ch21: assert property (p_ch21) else $error("chan21");
  property p_rd; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("rdata idle");
endmodule
bind event_routing_selector event_routing_checker event_routing_checker_i (.*);

/* verif/event_routing_selector_tb.sv */
`timescale 1ns/1ps
module event_routing_selector_tb;
  logic clk_i, rst_b_i, wr_i, rd_i, irq_o, nmi_i, host_event_i;
  logic timer_zero_event_i, timer_one_event_i, timer_two_event_i;
  logic memif_a_refresh_event_i, memif_b_refresh_event_i;
  logic transfer_complete_event_i, debug_dma_event_i;
  logic debug_exchange_rx_event_i, debug_exchange_tx_event_i;
  logic cell_interface_event_i, cell_rx_sync_i, cell_tx_sync_i;
  logic conv_decoder_event_i, iter_decoder_event_i;
  logic conv_decoder_rx_sync_i, conv_decoder_tx_sync_i;
  logic iter_decoder_rx_sync_i, iter_decoder_tx_sync_i;
  logic [2:0] serial_tx_event_i, serial_rx_event_i;
  logic [2:0] serial_tx_sync_i, serial_rx_sync_i;
  logic [15:0] gpio_event_i, cpu_int_o;
  logic [31:0] addr_i, wdata_i, rdata_o, sl, sh, src;
  logic [63:0] chain_complete_i, alt_chain_complete_i, chan_event_o, cap;
  localparam logic [31:0] ok_code = 32'hc09fffff;
  integer seed = 32'he043;
  int err_count, compares;
  event_routing_selector event_routing_selector_i (.*);
  core_event_sink core_event_sink_i (.clk_i, .rst_b_i,
    .chan_event_i(chan_event_o), .captured_o(cap));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [31:0] a, e, input string n);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(n, rdata_o, e);
    @(posedge clk_i);
  endtask
  task automatic irq_is(input logic e);
    @(posedge clk_i);
    #1 chk("irq", {31'h0, irq_o}, {31'h0, e});
    @(posedge clk_i);
  endtask
  // Bit c of s feeds the source whose selector code is c
  task automatic drv(input logic [31:0] s, x);
    {memif_a_refresh_event_i, timer_one_event_i, timer_zero_event_i,
      host_event_i} <= s[3:0];
    gpio_event_i <= {x[7:0], s[7:4], x[10:8], s[16]};
    {debug_exchange_tx_event_i, debug_exchange_rx_event_i,
      debug_dma_event_i, transfer_complete_event_i} <= s[11:8];
    serial_tx_event_i <= {s[17], s[14], s[12]};
    serial_rx_event_i <= {s[18], s[15], s[13]};
    {memif_b_refresh_event_i, timer_two_event_i} <= s[20:19];
    {iter_decoder_event_i, conv_decoder_event_i, cell_interface_event_i}
      <= {s[31:30], s[23]};
    {serial_tx_sync_i, serial_rx_sync_i, cell_rx_sync_i, cell_tx_sync_i,
      conv_decoder_rx_sync_i, conv_decoder_tx_sync_i,
      iter_decoder_rx_sync_i, iter_decoder_tx_sync_i, nmi_i} <= x[23:11];
    chain_complete_i <= {x[31:24], 56'h0};
    alt_chain_complete_i <= {56'h0, x[31:24]};
  endtask
  // reserved codes folded
  // Reserved codes are never written, so they are folded onto legal ones
  function automatic logic [31:0] rnd_sel(input logic [31:0] r);
    for (int k = 0; k < 6; k++) begin
      if (!ok_code[r[5*k+(k>2) +: 5]]) r[5*k+(k>2) +: 5] &= 5'h13;
    end
    return r;
  endfunction
  function automatic logic [31:0] exp_int(input logic [31:0] l, h, s);
    logic [31:0] r;
    exp_int = 32'h0;
    for (int j = 0; j < 12; j++) begin
      r = j < 6 ? l : h;
      exp_int[j+4] = s[r[5*(j%6)+(j%6>2) +: 5]];
    end
  endfunction
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    report_and_stop();
  end
  initial begin
    {rst_b_i, wr_i, rd_i, addr_i, wdata_i} = '0;
    drv(32'h0, 32'h0);
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    sl = {1'b0, 5'h09, 5'h08, 5'h07, 1'b0, 5'h06, 5'h05, 5'h04};
    sh = {1'b0, 5'h02, 5'h01, 5'h00, 1'b0, 5'h0b, 5'h0a, 5'h03};
    rd(32'h019c0010, 32'h0, "unmapped");
    for (int n = 0; n < 40; n++) begin
      if (n > 0) begin
        sl = rnd_sel($random(seed));
        sh = rnd_sel($random(seed));
        wr(32'h019c0004, sl);
        wr(32'h019c0000, sh);
      end
      rd(32'h019c0004, sl & 32'h7fff7fff, "sel_low");
      rd(32'h019c0000, sh & 32'h7fff7fff, "sel_high");
      src = $random(seed);
      drv(src, $random(seed));
      @(posedge clk_i);
      #1 chk("cpu_int", {16'h0, cpu_int_o & 16'hfff0}, exp_int(sl, sh, src));
      @(posedge clk_i);
    end
    drv(32'h0, 32'h0);
    repeat (3) @(posedge clk_i);
    wr(32'h019c0008, 32'hffff);
    wr(32'h019c000c, 32'hffff);
    rd(32'h019c0008, 32'h0, "status");
    drv(32'hffffffff, 32'h0);
    @(posedge clk_i);
    drv(32'h0, 32'h0);
    repeat (3) @(posedge clk_i);
    irq_is(1'b1);
    rd(32'h019c0008, 32'hfff0, "status");
    wr(32'h019c000c, 32'h0);
    irq_is(1'b0);
    wr(32'h019c0008, 32'hfff0);
    wr(32'h019c000c, 32'hffff);
    irq_is(1'b0);
    chk("idle_chan", cap[47:16] & 32'hfefe0fe1, 32'h0);
    report_and_stop();
  end
endmodule
